/* include/spsh_pkg.sv */
// Constants and helpers shared by the serial packet handler and its UART.
// Assumes one 25 MHz system clock; all timing counts derive from it.
package spsh_pkg;
  // Frame bytes
  localparam logic [7:0] SYNC_FF = 8'hFF;
  localparam logic [7:0] SYNC_LAST = 8'hFD;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  localparam logic [7:0] BCAST_ID = 8'hFE;
  localparam logic [7:0] MAX_UNIT_ID = 8'hFC;
  localparam logic [7:0] STATUS_INSTR = 8'h55;
  localparam logic [15:0] REQ_LEN_OVERHEAD = 16'h0003;
  localparam logic [15:0] STATUS_LEN_FIXED = 16'h0004;
  localparam int ALERT_BIT = 7;
  // Instruction codes
  localparam logic [7:0] INSTR_PING = 8'h01;
  localparam logic [7:0] INSTR_READ = 8'h02;
  localparam logic [7:0] INSTR_WRITE = 8'h03;
  localparam logic [7:0] INSTR_SHADOW = 8'h04;
  localparam logic [7:0] INSTR_COMMIT = 8'h05;
  localparam logic [7:0] INSTR_FACTORY = 8'h06;
  localparam logic [7:0] INSTR_REBOOT = 8'h08;
  // Error numbers
  localparam logic [6:0] ERR_NONE = 7'h00;
  localparam logic [6:0] ERR_PROCESS = 7'h01;
  localparam logic [6:0] ERR_INSTR = 7'h02;
  localparam logic [6:0] ERR_CRC = 7'h03;
  // Character framing
  localparam logic [3:0] UART_DATA_BITS = 4'h8;
  localparam logic [3:0] UART_STOP_BITS = 4'h1;
  localparam logic [3:0] UART_LAST_BIT = UART_DATA_BITS + UART_STOP_BITS;
  // Check code
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int RED_TIME_MS = 1000;
  localparam int RED_CYCLES = CLK_HZ / 1000 * RED_TIME_MS;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'h00D9;

  // One byte of the check code, MSB first, no reflection
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Check code state after the three sync bytes
  localparam logic [15:0] SYNC_CRC =
    crc16_byte(crc16_byte(crc16_byte(CRC_INIT, SYNC_FF), SYNC_FF), SYNC_LAST);
endpackage

/* design/spsh_uart.sv */
// Half-duplex 8N1 character engine for the shared serial line.
// Assumes rst_n is already synchronised and line_in is synchronous.
`timescale 1ns/100ps
module spsh_uart
  import spsh_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronised reset
  input wire logic [15:0] baud_div, // Clocks per bit
  input wire logic line_in, // Line level
  output logic line_out, // Line drive value
  output logic line_oe_n, // Low while driving
  output logic rx_valid, // Byte received pulse
  output logic [7:0] rx_data, // Received byte
  input wire logic tx_start, // Send request
  input wire logic [7:0] tx_data, // Byte to send
  output logic tx_busy // Sender active
);
  typedef struct packed {
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic tx_out;
    logic tx_oe_n;
  } spsh_uart_st_t;

  spsh_uart_st_t r;
  spsh_uart_st_t next_r;

  // Receiver and sender; the receiver is deaf while we drive
  always_comb
  begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    if (!r.rx_busy)
    begin
      if (!r.tx_busy && !line_in)
      begin
        next_r.rx_busy = 1'b1;
        next_r.rx_cnt = baud_div >> 1;
        next_r.rx_bit = 4'h0;
      end
    end
    else if (r.rx_cnt != 16'h0000)
      next_r.rx_cnt = r.rx_cnt - 16'h0001;
    else
    begin
      next_r.rx_cnt = baud_div - 16'h0001;
      next_r.rx_bit = r.rx_bit + 4'h1;
      if (r.rx_bit == 4'h0)
        next_r.rx_busy = !line_in; // Glitch, not a start bit
      else if (r.rx_bit <= UART_DATA_BITS)
        next_r.rx_sh = {line_in, r.rx_sh[7:1]};
      else
      begin
        next_r.rx_busy = 1'b0;
        next_r.rx_valid = line_in; // Framing error drops the byte
        next_r.rx_data = r.rx_sh;
      end
    end
    if (!r.tx_busy)
    begin
      if (tx_start)
      begin
        next_r.tx_busy = 1'b1;
        next_r.tx_sh = {1'b1, tx_data}; // Stop bit rides above the data
        next_r.tx_out = 1'b0;
        next_r.tx_oe_n = 1'b0;
        next_r.tx_cnt = baud_div - 16'h0001;
        next_r.tx_bit = 4'h0;
      end
    end
    else if (r.tx_cnt != 16'h0000)
      next_r.tx_cnt = r.tx_cnt - 16'h0001;
    else if (r.tx_bit == UART_LAST_BIT)
    begin
      next_r.tx_busy = 1'b0;
      next_r.tx_out = 1'b1;
      next_r.tx_oe_n = 1'b1; // Release the line after the stop bit
    end
    else
    begin
      next_r.tx_out = r.tx_sh[0];
      next_r.tx_sh = {1'b1, r.tx_sh[8:1]};
      next_r.tx_bit = r.tx_bit + 4'h1;
      next_r.tx_cnt = baud_div - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      r <= '{tx_out: 1'b1, tx_oe_n: 1'b1, default: '0};
    else
      r <= next_r;
  end

  assign line_out = r.tx_out;
  assign line_oe_n = r.tx_oe_n;
  assign rx_valid = r.rx_valid;
  assign rx_data = r.rx_data;
  assign tx_busy = r.tx_busy;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_tx_begin;
    tx_start && !r.tx_busy;
  endsequence
  sequence s_start_bit;
    !r.tx_out && !r.tx_oe_n && r.tx_bit == 4'h0;
  endsequence
  line_owner_a: assert property (!r.tx_oe_n |-> !r.rx_busy)
    else $error("receiver active while driving the line");
  start_bit_a: assert property (s_tx_begin |=> s_start_bit)
    else $error("character did not open with a start bit");
endmodule

/* design/spsh_packet_handler.sv */
// Packet handler for the servo serial link: request parse, check, status reply.
// Assumes one clock, synchronous pins and an executor on the cmd/exec ports.
`timescale 1ns/100ps
module spsh_packet_handler
  import spsh_pkg::*;
#(
  parameter int RESP_DEPTH = 16,
  parameter int MAX_ARGS = 16,
  parameter int RED_TIME_CYCLES = RED_CYCLES
)
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic line_in, // Serial line level
  output logic line_out, // Serial line drive value
  output logic line_oe_n, // Low while driving the line
  input wire logic [7:0] unit_id, // This unit's ID, 0..252
  input wire logic [15:0] baud_div, // Clocks per bit
  input wire logic hw_alert, // Hardware status shows a fault
  input wire logic servo_ok, // Green light state
  output logic arg_valid, // Argument byte pulse
  output logic arg_first, // First argument of a frame
  output logic [7:0] arg_data, // Argument byte
  output logic cmd_valid, // Checked request pulse
  output logic [7:0] cmd_instr, // Its instruction
  output logic cmd_broadcast, // It was broadcast
  input wire logic exec_wr, // Reply argument strobe
  input wire logic [7:0] exec_wdata, // Reply argument byte
  input wire logic exec_done, // Executor finished
  input wire logic [6:0] exec_err, // Executor error number
  output logic led_red, // Red indicator
  output logic led_green // Green indicator
);
  localparam int RA_W = $clog2(RESP_DEPTH);

  typedef enum logic [3:0] {
    ST_HUNT = 4'b0000,
    ST_HDR = 4'b0001,
    ST_INSTR = 4'b0011,
    ST_PARAM = 4'b0010,
    ST_CRCL = 4'b0110,
    ST_CRCH = 4'b0111,
    ST_EXEC = 4'b0101,
    ST_SEND = 4'b0100
  } spsh_state_t;

  typedef struct packed {
    spsh_state_t state;
    logic [1:0] sync_idx;
    logic [1:0] hcnt;
    logic [7:0] id;
    logic bcast;
    logic [15:0] len;
    logic [7:0] instr;
    logic [15:0] pcnt;
    logic toolong;
    logic first;
    logic [15:0] crc;
    logic [7:0] crc_lo;
    logic [6:0] err;
    logic [7:0] err_byte;
    logic pending;
    logic [7:0] wptr;
    logic [7:0] count;
    logic [7:0] tidx;
    logic [15:0] tcrc;
    logic tx_start;
    logic [7:0] tx_data;
    logic tx_pend;
    logic arg_valid;
    logic arg_first;
    logic [7:0] arg_data;
    logic cmd_valid;
    logic [7:0] cmd_instr;
    logic cmd_bcast;
    logic [31:0] led_cnt;
    logic led_done;
    logic led_red;
    logic led_green;
  } spsh_top_st_t;

  spsh_top_st_t r;
  spsh_top_st_t next_r;
  logic rst_meta;
  logic rst_n;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_busy;
  logic [7:0] resp_mem [RESP_DEPTH];
  logic for_me;
  logic [15:0] rlen;
  logic [7:0] sbyte;
  logic [7:0] ridx;

  function automatic logic instr_known(input logic [7:0] i);
    return i inside {INSTR_PING, INSTR_READ, INSTR_WRITE, INSTR_SHADOW,
                     INSTR_COMMIT, INSTR_FACTORY, INSTR_REBOOT};
  endfunction

  function automatic logic is_write(input logic [7:0] i);
    return i == INSTR_WRITE || i == INSTR_SHADOW;
  endfunction

  function automatic logic zero_err(input logic [7:0] i);
    return i == INSTR_FACTORY || i == INSTR_REBOOT;
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  spsh_uart u_uart (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .baud_div(baud_div),
    .line_in(line_in),
    .line_out(line_out),
    .line_oe_n(line_oe_n),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_start(r.tx_start),
    .tx_data(r.tx_data),
    .tx_busy(tx_busy)
  );

  // Reply arguments from the executor; no reset needed for data
  always_ff @(posedge clk_sys)
  begin
    if (exec_wr && r.wptr < 8'(RESP_DEPTH))
      resp_mem[r.wptr[RA_W-1:0]] <= exec_wdata;
  end

  // Status frame byte at the current send index
  assign for_me = (r.id == unit_id) || r.bcast;
  assign rlen = 16'(r.count) + STATUS_LEN_FIXED;
  assign ridx = r.tidx - 8'h09;
  always_comb
  begin
    case (r.tidx)
      8'h00, 8'h01: sbyte = SYNC_FF;
      8'h02: sbyte = SYNC_LAST;
      8'h03: sbyte = RSVD_BYTE;
      8'h04: sbyte = unit_id;
      8'h05: sbyte = rlen[7:0]; // Low byte first
      8'h06: sbyte = rlen[15:8];
      8'h07: sbyte = STATUS_INSTR;
      8'h08: sbyte = r.err_byte;
      default:
        if (r.tidx < r.count + 8'h09)
          sbyte = resp_mem[ridx[RA_W-1:0]];
        else if (r.tidx == r.count + 8'h09)
          sbyte = r.tcrc[7:0];
        else
          sbyte = r.tcrc[15:8];
    endcase
  end

  // Frame parser, executor hand-off, status sender and power-up light
  always_comb
  begin
    next_r = r;
    next_r.cmd_valid = 1'b0;
    next_r.arg_valid = 1'b0;
    next_r.arg_first = 1'b0;
    next_r.tx_start = 1'b0;
    // Red for a fixed time after reset, then green by state
    if (!r.led_done)
    begin
      if (r.led_cnt == 32'(RED_TIME_CYCLES - 1))
        next_r.led_done = 1'b1;
      else
        next_r.led_cnt = r.led_cnt + 32'h00000001;
    end
    next_r.led_red = !next_r.led_done;
    next_r.led_green = next_r.led_done && servo_ok;
    if (exec_wr && r.wptr < 8'(RESP_DEPTH))
      next_r.wptr = r.wptr + 8'h01;
    case (r.state)
      ST_HUNT:
        if (rx_valid)
        begin
          // A stray FF keeps the partial match alive
          next_r.crc = SYNC_CRC;
          case (r.sync_idx)
            2'h0: next_r.sync_idx = (rx_data == SYNC_FF) ? 2'h1 : 2'h0;
            2'h1: next_r.sync_idx = (rx_data == SYNC_FF) ? 2'h2 : 2'h0;
            2'h2:
              if (rx_data == SYNC_LAST)
              begin
                next_r.state = ST_HDR;
                next_r.hcnt = 2'h0;
                next_r.sync_idx = 2'h0;
              end
              else if (rx_data != SYNC_FF)
                next_r.sync_idx = 2'h0;
            default: next_r.sync_idx = 2'h0;
          endcase
        end
      ST_HDR:
        if (rx_valid)
        begin
          next_r.crc = crc16_byte(r.crc, rx_data);
          next_r.hcnt = r.hcnt + 2'h1;
          case (r.hcnt)
            2'h0: if (rx_data != RSVD_BYTE) next_r.state = ST_HUNT;
            2'h1:
            begin
              next_r.id = rx_data;
              next_r.bcast = (rx_data == BCAST_ID);
            end
            2'h2: next_r.len[7:0] = rx_data;
            default:
            begin
              next_r.len[15:8] = rx_data;
              next_r.pcnt = {rx_data, r.len[7:0]} - REQ_LEN_OVERHEAD;
              next_r.toolong = next_r.pcnt > 16'(MAX_ARGS);
              // Too short to hold an instruction and check code
              if ({rx_data, r.len[7:0]} < REQ_LEN_OVERHEAD)
                next_r.state = ST_HUNT;
              else
                next_r.state = ST_INSTR;
            end
          endcase
        end
      ST_INSTR:
        if (rx_valid)
        begin
          next_r.crc = crc16_byte(r.crc, rx_data);
          next_r.instr = rx_data;
          next_r.first = 1'b1;
          next_r.state = (r.pcnt == 16'h0000) ? ST_CRCL : ST_PARAM;
        end
      ST_PARAM:
        if (rx_valid)
        begin
          next_r.crc = crc16_byte(r.crc, rx_data);
          next_r.pcnt = r.pcnt - 16'h0001;
          // Foreign frames are parsed to stay in step but never forwarded
          if (for_me && !r.toolong)
          begin
            next_r.arg_valid = 1'b1;
            next_r.arg_first = r.first;
            next_r.arg_data = rx_data;
            next_r.first = 1'b0;
          end
          if (r.pcnt == 16'h0001)
            next_r.state = ST_CRCL;
        end
      ST_CRCL:
        if (rx_valid)
        begin
          next_r.crc_lo = rx_data;
          next_r.state = ST_CRCH;
        end
      ST_CRCH:
        if (rx_valid)
        begin
          next_r.wptr = 8'h00;
          if (!for_me)
            next_r.state = ST_HUNT;
          else
          begin
            next_r.state = ST_EXEC;
            if ({rx_data, r.crc_lo} != r.crc)
              next_r.err = ERR_CRC;
            else if (r.toolong)
              next_r.err = ERR_PROCESS;
            else if (!instr_known(r.instr) || (r.instr == INSTR_COMMIT && !r.pending))
              next_r.err = ERR_INSTR;
            else
            begin
              next_r.err = ERR_NONE;
              next_r.cmd_valid = 1'b1;
              next_r.cmd_instr = r.instr;
              next_r.cmd_bcast = r.bcast;
            end
          end
        end
      ST_EXEC:
        if (r.err != ERR_NONE || exec_done)
        begin
          // Range, length, limit and access errors come from the executor
          if (r.err == ERR_NONE)
            next_r.err = exec_err;
          next_r.count = (next_r.err == ERR_NONE) ? r.wptr : 8'h00;
          if (next_r.err == ERR_NONE && r.instr == INSTR_SHADOW)
            next_r.pending = 1'b1;
          if (next_r.err == ERR_NONE && r.instr == INSTR_COMMIT)
            next_r.pending = 1'b0;
          if (zero_err(r.instr))
            next_r.err_byte = 8'h00;
          else
            next_r.err_byte = {hw_alert, next_r.err};
          next_r.tidx = 8'h00;
          next_r.tcrc = CRC_INIT;
          next_r.tx_pend = 1'b0;
          if (r.bcast && is_write(r.instr))
            next_r.state = ST_HUNT;
          else
            next_r.state = ST_SEND;
        end
      ST_SEND:
        // One byte per character; the receiver stays deaf meanwhile
        if (r.tx_pend)
        begin
          if (tx_busy)
            next_r.tx_pend = 1'b0;
        end
        else if (!tx_busy)
        begin
          if (r.tidx == r.count + 8'h0B)
            next_r.state = ST_HUNT;
          else
          begin
            next_r.tx_start = 1'b1;
            next_r.tx_data = sbyte;
            next_r.tx_pend = 1'b1;
            next_r.tidx = r.tidx + 8'h01;
            if (r.tidx < r.count + 8'h09)
              next_r.tcrc = crc16_byte(r.tcrc, sbyte);
          end
        end
      default: next_r.state = ST_HUNT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      r <= '{state: ST_HUNT, led_red: 1'b1, default: '0};
    else
      r <= next_r;
  end

  assign arg_valid = r.arg_valid;
  assign arg_first = r.arg_first;
  assign arg_data = r.arg_data;
  assign cmd_valid = r.cmd_valid;
  assign cmd_instr = r.cmd_instr;
  assign cmd_broadcast = r.cmd_bcast;
  assign led_red = r.led_red;
  assign led_green = r.led_green;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_bad_crc;
    r.state == ST_CRCH && rx_valid && for_me && {rx_data, r.crc_lo} != r.crc;
  endsequence
  sequence s_bcast_write_done;
    r.state == ST_EXEC && r.bcast && is_write(r.instr) && (r.err != ERR_NONE || exec_done);
  endsequence

  status_instr_a: assert property (r.tx_start && r.tidx == 8'h08 |->
      r.tx_data == STATUS_INSTR)
    else $error("status instruction byte wrong");
  status_len_a: assert property (r.tx_start && r.tidx == 8'h06 |->
      r.tx_data == 8'(r.count + 8'h04))
    else $error("status length low byte wrong");
  zero_err_a: assert property (r.tx_start && r.tidx == 8'h09 && zero_err(r.instr) |->
      r.tx_data == 8'h00)
    else $error("reset-type reply carries an error");
  alert_bit_a: assert property (r.state == ST_EXEC && exec_done && !zero_err(r.instr) |=>
      r.err_byte[ALERT_BIT] == $past(hw_alert))
    else $error("alert bit does not follow hardware status");
  crc_err_a: assert property (s_bad_crc |=> r.state == ST_EXEC && r.err == ERR_CRC
      && !r.cmd_valid)
    else $error("check code mismatch not reported");
  bcast_quiet_a: assert property (s_bcast_write_done |=> r.state == ST_HUNT ##1
      !r.tx_start)
    else $error("reply sent to broadcast write");
  own_frame_a: assert property (r.cmd_valid |-> r.cmd_bcast || r.id == unit_id)
    else $error("request for another unit executed");
  commit_a: assert property (r.cmd_valid && r.cmd_instr == INSTR_COMMIT |->
      $past(r.pending))
    else $error("commit executed with nothing pending");
  sync_hunt_a: assert property (r.state == ST_HUNT && rx_valid && r.sync_idx != 2'h2 |=>
      r.state == ST_HUNT)
    else $error("header entered before full sync");
  led_a: assert property (r.led_red |-> !r.led_green && !r.led_done)
    else $error("both lights on at power-up");
  led_time_a: assert property ($fell(r.led_red) |->
      r.led_cnt == 32'(RED_TIME_CYCLES - 1))
    else $error("red light time wrong");
endmodule

/* tb/spsh_host_model.sv */
// Host-side serial bridge model: sends request characters, collects replies.
// Assumes a pull-up on the shared line; the host only pulls it low.
`timescale 1ns/100ps
module spsh_host_model #(
  parameter int BAUD = 8
)
(
  input wire logic clk_sys, // System clock
  input wire logic line, // Resolved line level
  output logic host_oe_n // Low while pulling the line low
);
  initial host_oe_n = 1'b1;

  // One 8N1 character, LSB first; a released 1 is left to the pull-up
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      host_oe_n <= f[i];
      repeat (BAUD) @(posedge clk_sys);
    end
  endtask

  // Hunts a start bit under a bound, samples mid-bit; ok low on silence
  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 0;
    b = 8'h00;
    while (line !== 1'b0 && n < 40 * BAUD)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n < 40 * BAUD)
    begin
      repeat (BAUD / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BAUD) @(posedge clk_sys);
        b[i] = line;
      end
      repeat (BAUD) @(posedge clk_sys);
      ok = (line === 1'b1);
    end
  endtask
endmodule

/* tb/servo_serial_packet_handler_test.sv */
// Self-checking bench for the packet handler with a host model and executor.
// Assumes baud_div 8 and a short red-light time; replies checked byte by byte.
`timescale 1ns/100ps
module servo_serial_packet_handler_test;
  import spsh_pkg::*;
  localparam logic [7:0] UNIT = 8'h21;
  logic clk_sys, reset_n, hw_alert, servo_ok, exec_wr, exec_done, host_oe_n;
  logic line_out, line_oe_n, arg_valid, arg_first, cmd_valid, cmd_broadcast;
  logic led_red, led_green;
  logic [7:0] exec_wdata, arg_data, cmd_instr, exp_instr;
  logic [6:0] exec_err, x_err;
  logic [31:0] lfsr = 32'h98EB;
  logic [7:0] rsp[$];
  logic [7:0] seen[$];
  int err_total, check_count, cyc, cmd_seen;
  bit drove, pend, exp_bc;
  // Pull-up wire: either party may pull low
  wire line = (line_oe_n | line_out) & host_oe_n;

  spsh_packet_handler #(.RED_TIME_CYCLES(100)) spsh_packet_handler_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .line_in(line), .line_out(line_out),
    .line_oe_n(line_oe_n), .unit_id(UNIT), .baud_div(16'h0008), .hw_alert(hw_alert),
    .servo_ok(servo_ok), .arg_valid(arg_valid), .arg_first(arg_first),
    .arg_data(arg_data), .cmd_valid(cmd_valid), .cmd_instr(cmd_instr),
    .cmd_broadcast(cmd_broadcast), .exec_wr(exec_wr), .exec_wdata(exec_wdata),
    .exec_done(exec_done), .exec_err(exec_err), .led_red(led_red),
    .led_green(led_green));
  spsh_host_model #(.BAUD(8)) spsh_host_model_inst (
    .clk_sys(clk_sys), .line(line), .host_oe_n(host_oe_n));

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  // Reference check code: zero start, MSB first, no reflection or inversion
  function automatic int crc16(input logic [7:0] f[$]);
    int c;
    c = 0;
    foreach (f[i])
    begin
      c ^= f[i] << 8;
      repeat (8) c = (c & 16'h8000) ? ((c << 1) ^ 16'h8005) & 16'hFFFF : (c << 1) & 16'hFFFF;
    end
    return c;
  endfunction

  // One request, a model of the expected outcome, and the reply compared
  task automatic xact(input logic [7:0] id, input logic [7:0] ins, input int na,
    input bit bad, input logic [6:0] e, input int nr);
    logic [7:0] f[$];
    logic [7:0] q[$];
    logic [7:0] b;
    bit ok, cmd, rep;
    int c, err;
    f = '{8'hFF, 8'hFF, 8'hFD, 8'h00, id, 8'(na + 3), 8'h00, ins};
    repeat (na) f.push_back(rnd());
    c = crc16(f) ^ int'(bad);
    err = bad ? 3 : (na > 16) ? 1 : 0;
    if (err == 0 && (!(ins inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08})
        || (ins == 8'h05 && !pend))) err = 2;
    cmd = err == 0 && (id == UNIT || id == BCAST_ID);
    rep = (id == UNIT || id == BCAST_ID) && !(id == BCAST_ID && ins inside {8'h03, 8'h04});
    if (cmd) err = e;
    if (cmd && e == 0 && ins == 8'h04) pend = 1;
    if (cmd && e == 0 && ins == 8'h05) pend = 0;
    rsp.delete();
    repeat (nr) rsp.push_back(rnd());
    q = '{8'hFF, 8'hFF, 8'hFD, 8'h00, UNIT, 8'((err == 0 ? nr : 0) + 4), 8'h00, 8'h55};
    q.push_back((ins inside {8'h06, 8'h08}) ? 8'h00 : {hw_alert, 7'(err)});
    if (err == 0) q = {q, rsp};
    q = {q, 8'(crc16(q)), 8'(crc16(q) >> 8)};
    exp_instr = ins;
    exp_bc = id == BCAST_ID;
    x_err = e;
    cmd_seen = 0;
    drove = 0;
    seen.delete();
    f = {f, 8'(c), 8'(c >> 8)};
    foreach (f[i]) spsh_host_model_inst.send_byte(f[i]);
    if (rep)
    begin
      foreach (q[i])
      begin
        spsh_host_model_inst.recv_byte(b, ok);
        chk8("reply byte", q[i], b);
        chk1("stop bit", 1'b1, ok);
      end
      repeat (16) @(posedge clk_sys);
    end
    else
    begin
      repeat (400) @(posedge clk_sys);
      chk1("silent", 1'b0, drove);
    end
    chk8("cmd count", 8'(cmd), 8'(cmd_seen));
    if (cmd)
      foreach (seen[i]) chk8("argument", f[8 + i], seen[i]);
    if (cmd) chk8("argument count", 8'(na), 8'(seen.size()));
  endtask

  // Executor stand-in, argument collector and line-ownership watch
  initial
  begin
    forever
    begin
      @(posedge clk_sys);
      if (cmd_valid === 1'b1)
      begin
        cmd_seen++;
        chk8("cmd_instr", exp_instr, cmd_instr);
        chk1("cmd_broadcast", exp_bc, cmd_broadcast);
        foreach (rsp[i])
        begin
          exec_wr <= 1'b1;
          exec_wdata <= rsp[i];
          @(posedge clk_sys);
        end
        exec_wr <= 1'b0;
        exec_err <= x_err;
        exec_done <= 1'b1;
        @(posedge clk_sys);
        exec_done <= 1'b0;
      end
    end
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (arg_valid === 1'b1)
    begin
      chk1("arg_first", seen.size() == 0, arg_first);
      seen.push_back(arg_data);
    end
    if (line_oe_n === 1'b0)
    begin
      drove = 1;
      chk1("host released", 1'b1, host_oe_n);
    end
    if (cyc == 70000)
    begin
      err_total++;
      finish_test();
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial
  begin
    {reset_n, hw_alert, exec_wr, exec_done, cyc, err_total, check_count} = '0;
    {exec_wdata, exec_err, x_err, exp_instr} = '0;
    servo_ok = rnd() > 8'h7F;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (50) @(posedge clk_sys);
    chk1("led_red on", 1'b1, led_red);
    repeat (70) @(posedge clk_sys);
    chk1("led_red off", 1'b0, led_red);
    chk1("led_green", servo_ok, led_green);
    spsh_host_model_inst.send_byte(8'hFF);
    spsh_host_model_inst.send_byte(8'h12);
    // A header with a bad reserved byte must drop back to the hunt
    for (int i = 0; i < 4; i++)
      spsh_host_model_inst.send_byte(i == 3 ? 8'h01 : i == 2 ? SYNC_LAST : SYNC_FF);
    xact(UNIT, 8'h01, 0, 0, 7'h00, 0);
    xact(UNIT, 8'h02, 4, 0, 7'h00, 3);
    for (int e = 4; e < 8; e++) xact(UNIT, 8'h03, 5, 0, 7'(e), 0);
    xact(UNIT, 8'h01, 0, 1, 7'h00, 0);
    xact(UNIT, 8'h02, 17, 0, 7'h00, 0);
    xact(UNIT, 8'h09, 0, 0, 7'h00, 0);
    xact(UNIT, 8'h05, 0, 0, 7'h00, 0);
    xact(UNIT, 8'h04, 5, 0, 7'h00, 0);
    xact(UNIT, 8'h05, 0, 0, 7'h00, 0);
    hw_alert <= 1'b1;
    @(posedge clk_sys); // The model reads hw_alert, so let the new level land first
    xact(UNIT, 8'h01, 0, 0, 7'h00, 0);
    // Host answers a raised alert by reading hardware status
    xact(UNIT, 8'h02, 4, 0, 7'h00, 2);
    xact(UNIT, 8'h06, 0, 0, 7'h05, 0);
    xact(UNIT, 8'h08, 0, 0, 7'h06, 0);
    hw_alert <= 1'b0;
    xact(8'h07, 8'h01, 0, 0, 7'h00, 0);
    xact(BCAST_ID, 8'h03, 5, 0, 7'h00, 0);
    xact(BCAST_ID, 8'h01, 0, 0, 7'h00, 0);
    finish_test();
  end
endmodule
